//--- logic/relay_flash_pkg.sv
// ***********************************************************
// relay output time function: shared types and constants
// ***********************************************************
package relay_flash_pkg;

	// ***********************************************************
	// timing
	// ***********************************************************
	// system clock period and time-base tick period, both in ns
	localparam int CLK_PERIOD_NS  = 50;
	localparam int TICK_PERIOD_NS = 100_000_000;
	// cycles of ref_clk per 0.1 s tick
	localparam int TICK_CYCLES    = TICK_PERIOD_NS / CLK_PERIOD_NS;

	// ***********************************************************
	// field widths and limits
	// ***********************************************************
	localparam int UNIT_W          = 16;
	localparam int PULSE_W         = 7;
	localparam logic [UNIT_W-1:0]  PHASE_MIN     = 16'h0005;
	localparam logic [UNIT_W-1:0]  PHASE_DEFAULT = 16'h000a;
	localparam logic [PULSE_W-1:0] PULSE_MIN     = 7'h01;
	localparam logic [PULSE_W-1:0] PULSE_MAX     = 7'h64;
	localparam logic [PULSE_W-1:0] PULSE_DEFAULT = 7'h05;
	localparam logic [UNIT_W-1:0]  UNIT_ONE      = 16'h0001;
	localparam logic [UNIT_W-1:0]  UNIT_ZERO     = 16'h0000;
	localparam logic [PULSE_W-1:0] PULSE_ONE     = 7'h01;

	// ***********************************************************
	// modes
	// ***********************************************************
	typedef enum logic [1:0] {
		PAIR_DISABLED = 2'h0,
		PAIR_SWITCH   = 2'h1,
		PAIR_BLIND    = 2'h2,
		PAIR_SHUTTER  = 2'h3
	} pairMode_t;

	typedef enum logic [1:0] {
		TF_STAIRCASE = 2'h0,
		TF_DELAY     = 2'h1,
		TF_FLASH     = 2'h2
	} timeFunc_t;

	typedef enum logic [1:0] {
		TRIG_ON   = 2'h0,
		TRIG_OFF  = 2'h1,
		TRIG_BOTH = 2'h2
	} flashTrig_t;

	typedef enum logic [1:0] {
		AFTER_ON       = 2'h0,
		AFTER_OFF      = 2'h1,
		AFTER_PREVIOUS = 2'h2
	} afterFlash_t;

	// gray sequence idle -> on -> off -> on ...
	typedef enum logic [1:0] {
		FL_IDLE = 2'b00,
		FL_ON   = 2'b01,
		FL_OFF  = 2'b11
	} flashState_t;

	// ***********************************************************
	// carriers
	// ***********************************************************
	typedef struct packed {
		flashTrig_t           trig;
		afterFlash_t          after;
		logic [UNIT_W-1:0]    onUnits;
		logic [UNIT_W-1:0]    offUnits;
		logic [PULSE_W-1:0]   pulseMax;
		logic                 invert;
	} flashCfg_t;

	typedef struct packed {
		logic [UNIT_W-1:0]    stairUnits;
		logic [UNIT_W-1:0]    delayOnUnits;
		logic [UNIT_W-1:0]    delayOffUnits;
	} timeCfg_t;

	typedef struct packed {
		logic stb;
		logic val;
	} telegram_t;

endpackage

//--- logic/tick_gen.sv
`timescale 1ns/10ps
// ***********************************************************
// time base: one-cycle pulse every CYCLES enabled clocks
// ***********************************************************
module tick_gen #(
	parameter int CYCLES = relay_flash_pkg::TICK_CYCLES
) (
	// clock and reset
	input  wire logic ref_clk,
	input  wire logic nrst,
	input  wire logic clkEn,
	// tick out
	output logic      tick_q
);
	localparam int CW = (CYCLES > 1) ? $clog2(CYCLES) : 1;
	localparam logic [CW-1:0] LAST = CW'(CYCLES - 1);

	logic [CW-1:0] div_q;

	// divider counts whole periods; frozen with the clock enable
	always_ff @(posedge ref_clk) begin
		if (!nrst) begin
			div_q  <= '0;
			tick_q <= 1'b0;
		end else if (clkEn) begin
			tick_q <= (div_q == LAST);
			if (div_q == LAST) begin
				div_q <= '0;
			end else begin
				div_q <= div_q + CW'(1);
			end
		end
	end
endmodule // tick_gen

//--- logic/relay_output_timer.sv
`timescale 1ns/10ps
// Contract
// - pair mode disabled, switch, blind or shutter; disabled ignores every command.
// - flashing works only when the time function is enabled.
// - permanent-on forces output on until a permanent-on telegram of 0; code also clears it whenever timeActive is low.
// - background functions keep running; contact takes their state when override ends.
// - time function selects staircase, on/off delay or flashing.
// - staircase on starts timer; output off immediately at expiry.
// - staircase startable by switch, either logic link, or scene recall.
// - delay mode applies on and off transitions after configured delays.
// - each flash period starts in on phase, energised NO, de-energised NC.
// - flashing may be inverted for a normally closed contact.
// - new switch value during flashing restarts period timing.
// - status output reports relay state, updated on each phase change.
// - trigger one: telegram 1 starts flashing, 0 stops it.
// - trigger zero: telegram 0 starts flashing, 1 stops it.
// - trigger either: 0 or 1 starts; flashing runs to pulse limit.
// - on phase lasts configured 0.1 s units, 5 to 65535, default 10.
// - off phase lasts configured 0.1 s units, 5 to 65535, default 10.
// - pulses counted; flashing ends at maximum, 1 to 100, default 5.
// - after flashing, output goes on, off, or its state before flashing.
module relay_output_timer #(
	parameter int TICK_CYCLES = relay_flash_pkg::TICK_CYCLES
) (
	// clock, reset, enable
	input  wire logic                       ref_clk,
	input  wire logic                       nrst,
	input  wire logic                       clkEn,
	// configuration
	input  wire relay_flash_pkg::pairMode_t pairMode,
	input  wire logic                       timeEnable,
	input  wire relay_flash_pkg::timeFunc_t timeFunc,
	input  wire logic                       normallyClosed,
	input  wire relay_flash_pkg::flashCfg_t flashCfg,
	input  wire relay_flash_pkg::timeCfg_t  timeCfg,
	// telegrams
	input  wire relay_flash_pkg::telegram_t switchTg,
	input  wire relay_flash_pkg::telegram_t link1Tg,
	input  wire relay_flash_pkg::telegram_t link2Tg,
	input  wire relay_flash_pkg::telegram_t sceneTg,
	input  wire relay_flash_pkg::telegram_t permOnTg,
	// outputs
	output logic                            relayOut_q,
	output logic                            statusOut_q,
	output logic                            flashing_q,
	output logic                            permOn_q
);
	// ***********************************************************
	// declarations
	// ***********************************************************
	relay_flash_pkg::flashState_t              flState_q;
	logic [relay_flash_pkg::UNIT_W-1:0]        phaseCnt_q;
	logic [relay_flash_pkg::PULSE_W-1:0]       pulseCnt_q;
	logic [relay_flash_pkg::UNIT_W-1:0]        stairCnt_q;
	logic [relay_flash_pkg::UNIT_W-1:0]        delayCnt_q;
	logic                                      delayPend_q;
	logic                                      delayVal_q;
	logic                                      funcState_q;
	logic                                      preFlash_q;
	logic                                      tick;
	logic                                      accept;
	logic                                      timeActive;
	logic                                      flashMode;
	logic                                      startHit;
	logic                                      stopHit;
	logic                                      flashStart;
	logic                                      flashStop;
	logic                                      flashEnd;
	logic                                      stairStart;
	logic                                      stairExpire;
	logic                                      delayExpire;
	logic                                      contact;
	logic                                      contact_d;
	logic                                      relay_d;
	logic [relay_flash_pkg::UNIT_W-1:0]        onUnits;
	logic [relay_flash_pkg::UNIT_W-1:0]        offUnits;
	logic [relay_flash_pkg::PULSE_W-1:0]       pulseMax;

	// ***********************************************************
	// time base
	// ***********************************************************
	// tenth-second tick
	tick_gen #(
		.CYCLES  (TICK_CYCLES)
	) u_tick (
		.ref_clk (ref_clk),
		.nrst    (nrst),
		.clkEn   (clkEn),
		.tick_q  (tick)
	);

	// ***********************************************************
	// mode decode
	// ***********************************************************
	// only a switch-actuator pair accepts commands
	assign accept     = (pairMode == relay_flash_pkg::PAIR_SWITCH);
	assign timeActive = accept && timeEnable;
	assign flashMode  = timeActive && (timeFunc == relay_flash_pkg::TF_FLASH);

	// on units clamped up to the least legal value
	assign onUnits  = (flashCfg.onUnits < relay_flash_pkg::PHASE_MIN) ? relay_flash_pkg::PHASE_MIN
	                                                                  : flashCfg.onUnits;
	// off units clamped the same way
	assign offUnits = (flashCfg.offUnits < relay_flash_pkg::PHASE_MIN) ? relay_flash_pkg::PHASE_MIN
	                                                                   : flashCfg.offUnits;
	// pulse limit kept inside its legal span
	assign pulseMax = (flashCfg.pulseMax < relay_flash_pkg::PULSE_MIN) ? relay_flash_pkg::PULSE_MIN :
	                  (flashCfg.pulseMax > relay_flash_pkg::PULSE_MAX) ? relay_flash_pkg::PULSE_MAX :
	                  flashCfg.pulseMax;

	// trigger decode for a switch telegram value
	always_comb begin
		startHit = 1'b0;
		stopHit  = 1'b0;
		case (flashCfg.trig)
			relay_flash_pkg::TRIG_ON: begin
				startHit = switchTg.val;
				stopHit  = !switchTg.val;
			end
			relay_flash_pkg::TRIG_OFF: begin
				startHit = !switchTg.val;
				stopHit  = switchTg.val;
			end
			relay_flash_pkg::TRIG_BOTH: begin
				startHit = 1'b1;
				stopHit  = 1'b0;
			end
			default: begin
				startHit = 1'b0;
				stopHit  = 1'b0;
			end
		endcase
	end

	assign flashStart = flashMode && switchTg.stb && startHit;
	assign flashStop  = flashMode && switchTg.stb && stopHit && (flState_q != relay_flash_pkg::FL_IDLE);
	// last off phase of the last pulse ends the run
	assign flashEnd   = flashStop || (flashMode && !switchTg.stb && tick && (flState_q == relay_flash_pkg::FL_OFF)
	                    && (phaseCnt_q == relay_flash_pkg::UNIT_ONE) && (pulseCnt_q >= pulseMax));

	// ***********************************************************
	// flashing engine
	// ***********************************************************
	// a new start telegram reloads timing; a mode change drops the run at once
	always_ff @(posedge ref_clk) begin
		if (!nrst) begin
			flState_q  <= relay_flash_pkg::FL_IDLE;
			phaseCnt_q <= relay_flash_pkg::UNIT_ZERO;
			pulseCnt_q <= '0;
		end else if (clkEn) begin
			if (!flashMode || flashEnd) begin
				flState_q <= relay_flash_pkg::FL_IDLE;
			end else if (flashStart) begin
				// period opens with the on phase
				flState_q  <= relay_flash_pkg::FL_ON;
				phaseCnt_q <= onUnits;
				pulseCnt_q <= relay_flash_pkg::PULSE_ONE;
			end else if (tick && (flState_q != relay_flash_pkg::FL_IDLE)) begin
				if (phaseCnt_q > relay_flash_pkg::UNIT_ONE) begin
					phaseCnt_q <= phaseCnt_q - relay_flash_pkg::UNIT_ONE;
				end else begin
					case (flState_q)
						relay_flash_pkg::FL_ON: begin
							flState_q  <= relay_flash_pkg::FL_OFF;
							phaseCnt_q <= offUnits;
						end
						relay_flash_pkg::FL_OFF: begin
							flState_q  <= relay_flash_pkg::FL_ON;
							phaseCnt_q <= onUnits;
							pulseCnt_q <= pulseCnt_q + relay_flash_pkg::PULSE_ONE;
						end
						default: begin
							flState_q <= relay_flash_pkg::FL_IDLE;
						end
					endcase
				end
			end
		end
	end

	// ***********************************************************
	// staircase and delay timers
	// ***********************************************************
	// staircase start sources
	assign stairStart  = timeActive && (timeFunc == relay_flash_pkg::TF_STAIRCASE) &&
	                     ((switchTg.stb && switchTg.val) || (link1Tg.stb && link1Tg.val) ||
	                      (link2Tg.stb && link2Tg.val) || (sceneTg.stb && sceneTg.val));
	assign stairExpire = timeActive && (timeFunc == relay_flash_pkg::TF_STAIRCASE) && tick &&
	                     (stairCnt_q == relay_flash_pkg::UNIT_ONE) && !stairStart;
	assign delayExpire = timeActive && (timeFunc == relay_flash_pkg::TF_DELAY) && delayPend_q && tick &&
	                     (delayCnt_q <= relay_flash_pkg::UNIT_ONE) && !switchTg.stb;

	// timers count ticks; a zero delay still waits for the next tick
	always_ff @(posedge ref_clk) begin
		if (!nrst) begin
			stairCnt_q  <= relay_flash_pkg::UNIT_ZERO;
			delayCnt_q  <= relay_flash_pkg::UNIT_ZERO;
			delayPend_q <= 1'b0;
			delayVal_q  <= 1'b0;
		end else if (clkEn) begin
			if (stairStart) begin
				stairCnt_q <= timeCfg.stairUnits;
			end else if (switchTg.stb && accept) begin
				stairCnt_q <= relay_flash_pkg::UNIT_ZERO;
			end else if (tick && (stairCnt_q != relay_flash_pkg::UNIT_ZERO)) begin
				stairCnt_q <= stairCnt_q - relay_flash_pkg::UNIT_ONE;
			end
			if (timeActive && (timeFunc == relay_flash_pkg::TF_DELAY) && switchTg.stb) begin
				delayPend_q <= 1'b1;
				delayVal_q  <= switchTg.val;
				delayCnt_q  <= switchTg.val ? timeCfg.delayOnUnits : timeCfg.delayOffUnits;
			end else if (delayExpire || !timeActive) begin
				delayPend_q <= 1'b0;
			end else if (tick && (delayCnt_q != relay_flash_pkg::UNIT_ZERO)) begin
				delayCnt_q <= delayCnt_q - relay_flash_pkg::UNIT_ONE;
			end
		end
	end

	// ***********************************************************
	// background contact state
	// ***********************************************************
	// keeps computing even under permanent-on
	always_ff @(posedge ref_clk) begin
		if (!nrst) begin
			funcState_q <= 1'b0;
			preFlash_q  <= 1'b0;
		end else if (clkEn && accept) begin
			if (flashStart && (flState_q == relay_flash_pkg::FL_IDLE)) begin
				preFlash_q <= funcState_q;
			end
			if (!timeEnable) begin
				if (switchTg.stb) begin
					funcState_q <= switchTg.val;
				end
			end else if (flashEnd) begin
				case (flashCfg.after)
					relay_flash_pkg::AFTER_ON:       funcState_q <= 1'b1;
					relay_flash_pkg::AFTER_OFF:      funcState_q <= 1'b0;
					relay_flash_pkg::AFTER_PREVIOUS: funcState_q <= preFlash_q;
					default:                         funcState_q <= 1'b0;
				endcase
			end else if (stairStart) begin
				funcState_q <= 1'b1;
			end else if (stairExpire) begin
				funcState_q <= 1'b0;
			end else if (delayExpire) begin
				funcState_q <= delayVal_q;
			end else if (switchTg.stb && (timeFunc == relay_flash_pkg::TF_STAIRCASE)) begin
				funcState_q <= switchTg.val;
			end
		end
	end

	// ***********************************************************
	// permanent-on override
	// ***********************************************************
	// held until a telegram of zero or until timeActive goes low
	always_ff @(posedge ref_clk) begin
		if (!nrst) begin
			permOn_q <= 1'b0;
		end else if (clkEn) begin
			if (!timeActive) begin
				permOn_q <= 1'b0;
			end else if (permOnTg.stb) begin
				permOn_q <= permOnTg.val;
			end
		end
	end

	// ***********************************************************
	// contact, relay and status
	// ***********************************************************
	assign contact   = (flState_q != relay_flash_pkg::FL_IDLE) ? (flState_q == relay_flash_pkg::FL_ON) : funcState_q;
	assign contact_d = permOn_q || contact;
	// normally closed drives the coil opposite
	// invert only affects a flashing NC contact
	assign relay_d   = contact_d ^ normallyClosed ^
	                   (normallyClosed && flashCfg.invert && (flState_q != relay_flash_pkg::FL_IDLE));

	// status follows every phase change one cycle later while permanent-on is low
	always_ff @(posedge ref_clk) begin
		if (!nrst) begin
			relayOut_q  <= 1'b0;
			statusOut_q <= 1'b0;
			flashing_q  <= 1'b0;
		end else if (clkEn) begin
			relayOut_q  <= relay_d;
			statusOut_q <= contact_d;
			flashing_q  <= (flState_q != relay_flash_pkg::FL_IDLE);
		end
	end

	// ***********************************************************
	// assertions
	// ***********************************************************
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!nrst);

	a_disabled_no_flash: assert property ((!accept && flState_q == relay_flash_pkg::FL_IDLE)
		|=> flState_q == relay_flash_pkg::FL_IDLE) else $error("flash started while pair disabled");
	a_flash_needs_time: assert property ((clkEn && !timeEnable)
		|=> flState_q == relay_flash_pkg::FL_IDLE) else $error("flashing without time function");
	a_permon_forces_on: assert property ((clkEn && permOn_q && timeActive && !permOnTg.stb) ##1 clkEn
		|=> statusOut_q) else $error("permanent-on did not hold the output on");
	a_flash_start_on: assert property ((clkEn && flashStart && !flashEnd)
		|=> (flState_q == relay_flash_pkg::FL_ON) && (phaseCnt_q == $past(onUnits)))
		else $error("bad flash start");
	// a phase count of zero or above its load would stretch or skip a phase
	a_phase_min_len: assert property ((clkEn && flState_q != relay_flash_pkg::FL_IDLE)
		|-> phaseCnt_q != relay_flash_pkg::UNIT_ZERO
		&& phaseCnt_q <= ((flState_q == relay_flash_pkg::FL_ON) ? onUnits : offUnits))
		else $error("phase counter left its range");
	a_pulse_limit: assert property ((flState_q != relay_flash_pkg::FL_IDLE)
		|-> pulseCnt_q <= pulseMax) else $error("pulse count above limit");
	a_after_flash_on: assert property ((clkEn && flashEnd && flashCfg.after == relay_flash_pkg::AFTER_ON)
		|=> funcState_q && flState_q == relay_flash_pkg::FL_IDLE) else $error("after-flash state not on");
	a_stair_expire_off: assert property ((clkEn && stairExpire && !flashEnd)
		|=> !funcState_q) else $error("staircase did not switch off at expiry");
	a_status_phase: assert property ((clkEn && !permOn_q && flState_q == relay_flash_pkg::FL_ON)
		|=> statusOut_q) else $error("status not on during on phase");
	a_both_no_stop: assert property ((clkEn && flashMode && flashCfg.trig == relay_flash_pkg::TRIG_BOTH
		&& flState_q != relay_flash_pkg::FL_IDLE && switchTg.stb)
		|=> flState_q == relay_flash_pkg::FL_ON) else $error("either-trigger telegram ended flashing");
endmodule // relay_output_timer

//--- tb/bus_peer.sv
`timescale 1ns/10ps
// ********************************
// bus peer: other devices sending telegrams
// ********************************
module bus_peer (
	// clock
	input  wire logic                 ref_clk,
	// telegrams toward the output
	output relay_flash_pkg::telegram_t switchTg,
	output relay_flash_pkg::telegram_t link1Tg,
	output relay_flash_pkg::telegram_t link2Tg,
	output relay_flash_pkg::telegram_t sceneTg,
	output relay_flash_pkg::telegram_t permOnTg
);
	relay_flash_pkg::telegram_t tg [5];

	// index 0 switch, 1 and 2 links, 3 scene, 4 permanent-on
	assign switchTg = tg[0];
	assign link1Tg  = tg[1];
	assign link2Tg  = tg[2];
	assign sceneTg  = tg[3];
	assign permOnTg = tg[4];

	// idle lines start low
	initial begin
		foreach (tg[i]) tg[i] = '0;
	end

	// one-cycle telegram, caller stands just after a rising edge; the value line then
	// carries the inverse so a stale value is never read as a fresh telegram
	task automatic send(input int src, input logic v);
		tg[src] = '{1'b1, v};
		@(posedge ref_clk);
		#1;
		tg[src] = '{1'b0, ~v};
	endtask
endmodule // bus_peer

//--- tb/relay_output_time_flash_control_bench.sv
`timescale 1ns/10ps
`define CHK(nm, ex, got) begin \
	check_count++; \
	if ((got) !== (ex)) begin \
		err_total++; \
		$display("ERROR %s expected %0h seen %0h", nm, ex, got); \
	end \
end
module relay_output_time_flash_control_bench;
	localparam int T = 10;
	logic                       ref_clk        = 1'b0;
	logic                       nrst           = 1'b0;
	logic                       clkEn          = 1'b1;
	relay_flash_pkg::pairMode_t pairMode       = relay_flash_pkg::PAIR_SWITCH;
	logic                       timeEnable     = 1'b0;
	relay_flash_pkg::timeFunc_t timeFunc       = relay_flash_pkg::TF_FLASH;
	logic                       normallyClosed = 1'b0;
	relay_flash_pkg::flashCfg_t flashCfg       = '0;
	relay_flash_pkg::timeCfg_t  timeCfg        = {16'h0003, 16'h0002, 16'h0002};
	relay_flash_pkg::telegram_t switchTg, link1Tg, link2Tg, sceneTg, permOnTg;
	logic                       relayOut_q, statusOut_q, flashing_q, permOn_q;
	int                         err_total      = 0;
	int                         check_count    = 0;
	int                         expState       = 0;
	int                         n;
	// trig, after, units, pulses (-1 random), nc, invert, action (1 stop, 2 restart)
	int                         runs [7][7]    = '{'{0,0,5,-1,0,0,0}, '{1,2,2,0,1,0,0}, '{2,1,6,-1,1,1,2},
		'{0,2,5,1,0,0,0}, '{2,0,5,101,0,0,0}, '{0,0,5,3,0,0,1}, '{1,0,5,3,0,0,1}};

	// 20 MHz clock
	always #25 ref_clk = ~ref_clk;

	bus_peer u_peer (
		.ref_clk  (ref_clk),
		.switchTg (switchTg),
		.link1Tg  (link1Tg),
		.link2Tg  (link2Tg),
		.sceneTg  (sceneTg),
		.permOnTg (permOnTg)
	);

	// short tick so phase counts stay cheap to simulate
	relay_output_timer #(.TICK_CYCLES(T)) u_relay_output_timer (
		.ref_clk        (ref_clk),
		.nrst           (nrst),
		.clkEn          (clkEn),
		.pairMode       (pairMode),
		.timeEnable     (timeEnable),
		.timeFunc       (timeFunc),
		.normallyClosed (normallyClosed),
		.flashCfg       (flashCfg),
		.timeCfg        (timeCfg),
		.switchTg       (switchTg),
		.link1Tg        (link1Tg),
		.link2Tg        (link2Tg),
		.sceneTg        (sceneTg),
		.permOnTg       (permOnTg),
		.relayOut_q     (relayOut_q),
		.statusOut_q    (statusOut_q),
		.flashing_q     (flashing_q),
		.permOn_q       (permOn_q)
	);

	// ********************************
	// helpers
	// ********************************
	task automatic step(input int k);
		repeat (k) begin
			@(posedge ref_clk);
			#1;
		end
	endtask

	task automatic close_out();
		if (err_total == 0 && check_count > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask

	// cycles until the status moves; a hang ends the run
	task automatic wait_change(output int c);
		logic s0;
		s0 = statusOut_q;
		c = 0;
		while (statusOut_q === s0) begin
			step(1);
			c++;
			if (c > 30000) begin
				err_total++;
				close_out();
			end
		end
	endtask

	// first tick of a phase may come up to one tick early, hence the window
	task automatic window(input string nm, input int c, input int lo, input int hi);
		`CHK(nm, 1'b1, (c >= lo && c <= hi))
	endtask

	// ********************************
	// one flash run against the reference
	// ********************************
	task automatic flash_run(input int trg, aft, onu, pm, nc, inv, act);
		int   u, pExp, len, lenOff, pulses, g, add;
		logic sv, prev;
		u = (onu < 5) ? 5 : onu;
		pExp = (pm < 1) ? 1 : (pm > 100) ? 100 : pm;
		add = (act == 2) ? 20 : 0;
		flashCfg = {2'(trg), 2'(aft), 16'(onu), 16'(onu), 7'(pm), 1'(inv)};
		normallyClosed = 1'(nc);
		sv = (trg == 1) ? 1'b0 : (trg == 2) ? 1'($urandom_range(1)) : 1'b1;
		u_peer.send(0, sv);
		step(1);
		`CHK("flashStart", 1'b1, flashing_q)
		`CHK("flashFirstOn", 1'b1, statusOut_q)
		if (act == 1) begin
			step(10);
			u_peer.send(0, ~sv);
			step(2);
			`CHK("flashStop", 1'b0, flashing_q)
			// a stopped run still lands on its configured end state
			expState = (aft == 0) ? 1 : (aft == 1) ? 0 : expState;
			`CHK("stopAfter", 1'(expState), statusOut_q)
			return;
		end
		len = 0;
		lenOff = 0;
		pulses = 1;
		prev = 1'b1;
		for (g = 0; g < 30000 && flashing_q === 1'b1; g++) begin
			`CHK("relayDrive", statusOut_q ^ 1'(nc & ~inv), relayOut_q)
			if (act == 2 && g == 20) u_peer.send(0, ~sv);
			else step(1);
			if (flashing_q === 1'b1) begin
				if (statusOut_q === 1'b1 && prev === 1'b0) pulses++;
				if (pulses == 1 && statusOut_q === 1'b1) len++;
				if (pulses == 1 && statusOut_q === 1'b0) lenOff++;
				prev = statusOut_q;
			end
		end
		if (g >= 30000) begin
			err_total++;
			close_out();
		end
		`CHK("pulses", pExp, pulses)
		window("onLen", len, add + (u - 1) * T - 2, add + u * T + 2);
		window("offLen", lenOff, (u - 1) * T - 2, u * T + 2);
		expState = (aft == 0) ? 1 : (aft == 1) ? 0 : expState;
		step(2);
		`CHK("afterFlash", 1'(expState), statusOut_q)
	endtask

	// ********************************
	// main sequence
	// ********************************
	initial begin
		void'($urandom(32'h59fd));
		repeat (8) @(posedge ref_clk);
		#1 nrst = 1'b1;
		step(1);
		`CHK("resetOut", 4'h0, {relayOut_q, statusOut_q, flashing_q, permOn_q})
		// pairs not set as switch actuator ignore commands
		for (int m = 0; m < 4; m++) begin
			if (m != 1) begin
				pairMode = relay_flash_pkg::pairMode_t'(m);
				u_peer.send(0, 1'b1);
				step(2);
				`CHK("pairIgnore", 1'b0, statusOut_q)
			end
		end
		pairMode = relay_flash_pkg::PAIR_SWITCH;
		// flash selected but time function off: plain switching
		u_peer.send(0, 1'b1);
		step(1);
		`CHK("noTimeFlash", 2'h2, {statusOut_q, flashing_q})
		u_peer.send(4, 1'b1);
		step(1);
		`CHK("permOnNoTime", 1'b0, permOn_q)
		u_peer.send(0, 1'b0);
		step(1);
		timeEnable = 1'b1;
		timeFunc = relay_flash_pkg::TF_STAIRCASE;
		// staircase from switch, both links and scene
		for (int s = 0; s < 4; s++) begin
			u_peer.send(s, 1'b1);
			step(1);
			`CHK("stairOn", 1'b1, statusOut_q)
			wait_change(n);
			window("stairLen", n, 2 * T - 2, 3 * T + 3);
		end
		// permanent-on holds, then hands over to the running staircase
		u_peer.send(4, 1'b1);
		step(1);
		`CHK("permOnSet", 2'h3, {permOn_q, statusOut_q})
		step(4 * T);
		`CHK("permOnHold", 1'b1, statusOut_q)
		// a low enable freezes all state, so this release must not be taken
		clkEn = 1'b0;
		u_peer.send(4, 1'b0);
		step(2);
		`CHK("enFreeze", 2'h3, {permOn_q, statusOut_q})
		clkEn = 1'b1;
		u_peer.send(0, 1'b1);
		u_peer.send(4, 1'b0);
		step(1);
		`CHK("permOnEnd", 2'h1, {permOn_q, statusOut_q})
		wait_change(n);
		window("stairBehind", n, 2 * T - 4, 3 * T + 3);
		// delayed switching in both directions
		timeFunc = relay_flash_pkg::TF_DELAY;
		for (int v = 1; v >= 0; v--) begin
			u_peer.send(0, 1'(v));
			wait_change(n);
			window("delayLen", n, T - 2, 2 * T + 4);
			`CHK("delayVal", 1'(v), statusOut_q)
		end
		timeFunc = relay_flash_pkg::TF_FLASH;
		expState = 0;
		foreach (runs[i]) begin
			flash_run(runs[i][0], runs[i][1], runs[i][2],
				(runs[i][3] < 0) ? 1 + $urandom_range(2) : runs[i][3], runs[i][4], runs[i][5], runs[i][6]);
		end
		close_out();
	end
endmodule // relay_output_time_flash_control_bench
